// ---- design/tape_connect_map.svh ----
`ifndef TAPE_CONNECT_MAP_SVH
`define TAPE_CONNECT_MAP_SVH

// ==========================================================
// Connect code layout
`define CODE_W 12
`define CODE_EQ_HI 11
`define CODE_EQ_LO 9
`define CODE_UNIT_HI 2
`define CODE_UNIT_LO 0
`define EQ_W 3
`define UNIT_IDX_W 3

// ==========================================================
// Transport side widths
`define NUM_UNITS 8
`define STATUS_W 11

// ==========================================================
// Reset and clear values
`define SEL_NONE 8'h00
`define ADDR_ALL_ZERO 8'h00
`define STATUS_NONE 11'h000

`endif

// ---- design/tape_connect_pkg.sv ----
`include "tape_connect_map.svh"

package tape_connect_pkg;

  // ==========================================================
  // Connect lines from the channel, grouped
  typedef struct packed {
    logic strobe;
    logic parity;
    logic [`CODE_W-1:0] code;
  } connect_bus_t;

  // Eight one-hot unit address words, one per transport
  typedef logic [`NUM_UNITS-1:0][`NUM_UNITS-1:0] unit_addr_t;

  // Eleven status lines per transport
  typedef logic [`NUM_UNITS-1:0][`STATUS_W-1:0] unit_status_t;

  // Timing chain steps
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_T1,
    ST_T2,
    ST_T3,
    ST_T4,
    ST_WAIT_DROP
  } chain_state_t;

  // Whole register state of the sequencer
  typedef struct packed {
    chain_state_t st;
    logic conn;
    logic cip;
    logic reply;
    logic reject;
    logic par_err;
    logic [`NUM_UNITS-1:0] sel;
    logic [`STATUS_W-1:0] status;
  } seq_state_t;

endpackage

// ---- design/pin_sync.sv ----
// ==========================================================
// Two-stage synchroniser for asynchronous pins
module pin_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      dout <= '0;
    end else if (clk_en) begin
      meta_q <= din;
      dout <= meta_q;
    end
  end

endmodule

// ---- design/parity_checker.sv ----
`include "tape_connect_map.svh"

// ==========================================================
// Odd transmission parity check over code plus parity bit
module parity_checker (
  input wire logic [`CODE_W-1:0] code,
  input wire logic parity_bit,
  output logic even_data_bits_term,
  output logic transmission_parity_fault
);

  // Even data with no parity, or odd data with parity, is a fault
  always_comb begin
    even_data_bits_term = ~(^code);
    transmission_parity_fault = even_data_bits_term ^ parity_bit;
  end

endmodule

// ---- design/tape_unit_connect_sequencer.sv ----
// What this block does
// - Connect only when code bits 11..9 equal the equipment number switch.
// - Decode code bits 2..0 into a one-of-eight transport selection.
// - Code bits 8..3 are ignored for selection; they count only in the parity check.
// - Channel sends odd parity; even total with parity is a transmission fault.
// - Parity fault sets the error flag and red lamp, not reported to channel.
// - Mismatch or parity fault: drop connected at step one, stop chain, no answer.
// - Operation active or tape moving: set reject, block step two, answer reject.
// - Connect strobe starts a four step timing chain sequencing the checks.
// - Connect-in-progress set at step one, cleared at step four.
// - Step two sets connected, clears all selects, lights the white lamp.
// - Matching transport selected and reply set together at step three, reply returned.
// - No matching transport: selects stay clear, reject set at step four.
// - Channel drops strobe on answer; device then clears and withdraws it.
// - After connect, enable operations and route selected transport to channel.
// - Select holds until clear, release, new connect or all-zero unit address.
// - A connect for another controller drops any existing connection here.
// - While connected, transport status is presented continuously.
// - Master clear clears connections and logic, presenting no status.
`include "tape_connect_map.svh"

module tape_unit_connect_sequencer
  import tape_connect_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic master_clear,
  input wire tape_connect_pkg::connect_bus_t connect_lines,
  input wire logic [`EQ_W-1:0] equipment_number_switch,
  input wire logic operation_active_term,
  input wire logic clear_function,
  input wire logic release_function,
  input wire tape_connect_pkg::unit_addr_t unit_address_lines,
  input wire tape_connect_pkg::unit_status_t transport_status,
  output logic reply,
  output logic reject,
  output logic controller_connected_flag,
  output logic connect_in_progress_flag,
  output logic transmission_parity_error_flag,
  output logic red_lamp_driver,
  output logic white_lamp_driver,
  output logic [`NUM_UNITS-1:0] unit_select,
  output logic operations_enable,
  output logic [`STATUS_W-1:0] status_lines
);

  import tape_connect_pkg::*;

  // ==========================================================
  // Pin synchronisation
  localparam int SYNC_W = $bits(connect_bus_t) + `EQ_W + 1 + $bits(unit_addr_t)
                          + $bits(unit_status_t);

  connect_bus_t conn_s;
  logic [`EQ_W-1:0] eq_sw_s;
  logic mc_s;
  unit_addr_t addr_s;
  unit_status_t stat_s;

  // Connect, switch, master clear, address and status pins cross through two flops; operation active, clear and release go straight in
  pin_sync #(
    .W(SYNC_W)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .din({connect_lines, equipment_number_switch, master_clear, unit_address_lines,
          transport_status}),
    .dout({conn_s, eq_sw_s, mc_s, addr_s, stat_s})
  );

  // ==========================================================
  // Code checks
  logic even_data_bits_term;
  logic parity_fault;
  logic equipment_mismatch_term;
  logic [`UNIT_IDX_W-1:0] unit_idx;
  logic [`NUM_UNITS-1:0] decoded_unit;
  logic [`NUM_UNITS-1:0] unit_match;
  logic [`NUM_UNITS-1:0] addr_zero;
  logic no_unit_match_term;
  logic unit_select_clear_term;

  parity_checker u_parity (
    .code(conn_s.code),
    .parity_bit(conn_s.parity),
    .even_data_bits_term(even_data_bits_term),
    .transmission_parity_fault(parity_fault)
  );

  // Equipment compare and unit decode; bits 8..3 enter only the parity check
  always_comb begin
    equipment_mismatch_term = conn_s.code[`CODE_EQ_HI:`CODE_EQ_LO] != eq_sw_s;
    unit_idx = conn_s.code[`CODE_UNIT_HI:`CODE_UNIT_LO];
    decoded_unit = `SEL_NONE;
    decoded_unit[unit_idx] = 1'b1;
  end

  // Per transport: compare decoded unit with its address lines
  for (genvar i = 0; i < `NUM_UNITS; i++) begin : g_unit
    assign unit_match[i] = |(decoded_unit & addr_s[i]);
    assign addr_zero[i] = addr_s[i] == `ADDR_ALL_ZERO;
  end

  assign no_unit_match_term = ~|unit_match;
  assign unit_select_clear_term = clear_function | release_function;

  // ==========================================================
  // Status routing from the selected transport
  seq_state_t r_q;
  seq_state_t r_d;
  logic [`STATUS_W-1:0] sel_status;

  always_comb begin
    sel_status = `STATUS_NONE;
    for (int k = 0; k < `NUM_UNITS; k++) begin
      if (r_q.sel[k]) begin
        sel_status = sel_status | stat_s[k];
      end
    end
  end

  // ==========================================================
  // Timing chain and flags
  always_comb begin
    r_d = r_q;
    // Accident: selector turned drops that transport's select
    for (int k = 0; k < `NUM_UNITS; k++) begin
      if (r_q.sel[k] && addr_zero[k]) begin
        r_d.sel[k] = 1'b0;
      end
    end
    if (unit_select_clear_term) begin
      r_d.sel = `SEL_NONE;
    end
    unique case (r_q.st)
      ST_IDLE: begin
        if (conn_s.strobe) begin
          r_d.st = ST_T1;
          r_d.par_err = 1'b0;
        end
      end
      ST_T1: begin
        r_d.cip = 1'b1;
        r_d.par_err = parity_fault;
        if (equipment_mismatch_term || parity_fault) begin
          // Not addressed here or bad parity: drop any connection, stop, stay silent
          r_d.conn = 1'b0;
          r_d.sel = `SEL_NONE;
          r_d.cip = 1'b0;
          r_d.st = ST_WAIT_DROP;
        end else if (operation_active_term) begin
          r_d.reject = 1'b1;
          r_d.cip = 1'b0;
          r_d.st = ST_WAIT_DROP;
        end else begin
          r_d.st = ST_T2;
        end
      end
      ST_T2: begin
        r_d.conn = 1'b1;
        r_d.sel = `SEL_NONE;
        r_d.st = ST_T3;
      end
      ST_T3: begin
        if (!no_unit_match_term) begin
          r_d.sel = unit_match;
          r_d.reply = 1'b1;
        end
        r_d.st = ST_T4;
      end
      ST_T4: begin
        r_d.cip = 1'b0;
        if (!r_q.reply) begin
          r_d.reject = 1'b1;
        end
        r_d.st = ST_WAIT_DROP;
      end
      ST_WAIT_DROP: begin
        if (!conn_s.strobe) begin
          r_d.reply = 1'b0;
          r_d.reject = 1'b0;
          r_d.st = ST_IDLE;
        end
      end
      default: begin
        r_d.st = ST_IDLE; // Unused codes fall back to idle
      end
    endcase
    // Status follows the selected transport only while connected
    r_d.status = r_q.conn ? sel_status : `STATUS_NONE;
    if (mc_s) begin
      r_d = '{st: ST_IDLE, sel: `SEL_NONE, status: `STATUS_NONE, default: 1'b0};
    end
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      r_q <= '{st: ST_IDLE, sel: `SEL_NONE, status: `STATUS_NONE, default: 1'b0};
    end else if (clk_en) begin
      r_q <= r_d;
    end
  end

  // ==========================================================
  // Outputs straight from state flops
  assign reply = r_q.reply;
  assign reject = r_q.reject;
  assign controller_connected_flag = r_q.conn;
  assign connect_in_progress_flag = r_q.cip;
  assign transmission_parity_error_flag = r_q.par_err;
  assign red_lamp_driver = r_q.par_err;
  assign white_lamp_driver = r_q.conn;
  assign unit_select = r_q.sel;
  assign operations_enable = r_q.conn;
  assign status_lines = r_q.status;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n || !clk_en || mc_s);

  logic t1_ok;
  assign t1_ok = r_q.st == ST_T1 && !equipment_mismatch_term && !parity_fault
                 && !operation_active_term;

  sequence s_chain_tail;
    r_q.st == ST_T2 ##1 r_q.st == ST_T3 ##1 r_q.st == ST_T4 ##1 r_q.st == ST_WAIT_DROP;
  endsequence

  property p_mismatch_silent;
    r_q.st == ST_T1 && equipment_mismatch_term
      |=> !r_q.conn && !r_q.reply && !r_q.reject && r_q.st == ST_WAIT_DROP;
  endproperty
  a_mismatch_silent: assert property (p_mismatch_silent)
    else $error("mismatch did not silently drop connection");

  property p_parity_lamp;
    r_q.st == ST_T1 && parity_fault |=> r_q.par_err && red_lamp_driver && !r_q.reject;
  endproperty
  a_parity_lamp: assert property (p_parity_lamp)
    else $error("parity fault not flagged or wrongly answered");

  property p_busy_reject;
    r_q.st == ST_T1 && !equipment_mismatch_term && !parity_fault && operation_active_term
      |=> r_q.reject && r_q.conn == $past(r_q.conn) && r_q.st == ST_WAIT_DROP
      ##1 r_q.st != ST_T2;
  endproperty
  a_busy_reject: assert property (p_busy_reject)
    else $error("busy connect not rejected");

  property p_chain_order;
    t1_ok |=> s_chain_tail;
  endproperty
  a_chain_order: assert property (p_chain_order)
    else $error("timing chain steps out of order");

  property p_step_two;
    r_q.st == ST_T2 |=> r_q.conn && white_lamp_driver && r_q.sel == `SEL_NONE;
  endproperty
  a_step_two: assert property (p_step_two)
    else $error("step two did not connect and clear selects");

  property p_reply_select;
    r_q.st == ST_T3 && !no_unit_match_term |=> r_q.reply && r_q.sel == $past(unit_match);
  endproperty
  a_reply_select: assert property (p_reply_select)
    else $error("matched transport not selected with reply");

  property p_nomatch_reject;
    r_q.st == ST_T3 && no_unit_match_term |=> ##1 r_q.reject && !r_q.reply && !r_q.cip;
  endproperty
  a_nomatch_reject: assert property (p_nomatch_reject)
    else $error("unmatched unit not rejected at step four");

  property p_withdraw;
    r_q.st == ST_WAIT_DROP && !conn_s.strobe |=> !reply && !reject && r_q.st == ST_IDLE;
  endproperty
  a_withdraw: assert property (p_withdraw)
    else $error("answer not withdrawn after strobe drop");

  property p_no_status_idle;
    !r_q.conn |=> status_lines == `STATUS_NONE;
  endproperty
  a_no_status_idle: assert property (p_no_status_idle)
    else $error("status shown while not connected");

  sequence s_cip_window;
    r_q.cip [*3] ##1 !r_q.cip;
  endsequence

  property p_cip_window;
    t1_ok |=> s_cip_window;
  endproperty
  a_cip_window: assert property (p_cip_window)
    else $error("connect in progress not held from step one to step four");

  property p_parity_silent;
    r_q.st == ST_T1 && parity_fault
      |=> !r_q.conn && !r_q.reply && r_q.st == ST_WAIT_DROP;
  endproperty
  a_parity_silent: assert property (p_parity_silent)
    else $error("parity fault did not stop the chain silently");

  property p_foreign_drop;
    r_q.st == ST_T1 && equipment_mismatch_term
      |=> r_q.sel == `SEL_NONE && !white_lamp_driver && !operations_enable;
  endproperty
  a_foreign_drop: assert property (p_foreign_drop)
    else $error("connect for another controller kept the connection");

  property p_strobe_start;
    r_q.st == ST_IDLE && conn_s.strobe |=> r_q.st == ST_T1 && !r_q.par_err;
  endproperty
  a_strobe_start: assert property (p_strobe_start)
    else $error("connect strobe did not start the timing chain");

  property p_hold_until_drop;
    r_q.st == ST_WAIT_DROP && conn_s.strobe |=> r_q.st == ST_WAIT_DROP;
  endproperty
  a_hold_until_drop: assert property (p_hold_until_drop)
    else $error("timing chain left its end state with strobe still up");

  property p_select_hold;
    (r_q.st == ST_IDLE || r_q.st == ST_WAIT_DROP) && !unit_select_clear_term
      && (r_q.sel & addr_zero) == `SEL_NONE |=> r_q.sel == $past(r_q.sel);
  endproperty
  a_select_hold: assert property (p_select_hold)
    else $error("unit select changed without a clearing cause");

  property p_function_clear;
    unit_select_clear_term && r_q.st != ST_T3 |=> r_q.sel == `SEL_NONE;
  endproperty
  a_function_clear: assert property (p_function_clear)
    else $error("clear or release function left a unit selected");

  property p_accident_clear;
    r_q.st != ST_T3 && (r_q.sel & addr_zero) != `SEL_NONE
      |=> (r_q.sel & $past(addr_zero)) == `SEL_NONE;
  endproperty
  a_accident_clear: assert property (p_accident_clear)
    else $error("select kept while its unit address went all zero");

  property p_status_route;
    r_q.conn |=> status_lines == $past(sel_status);
  endproperty
  a_status_route: assert property (p_status_route)
    else $error("status lines do not follow the selected transport");

  property p_master_clear;
    disable iff (!rst_n || !clk_en)
    mc_s |=> !r_q.conn && !r_q.reply && !r_q.reject && r_q.sel == `SEL_NONE
      && r_q.st == ST_IDLE && status_lines == `STATUS_NONE;
  endproperty
  a_master_clear: assert property (p_master_clear)
    else $error("master clear left connection or chain state behind");

endmodule

// ---- test/channel_model.sv ----
`include "tape_connect_map.svh"

// ==========================================================
// Data channel side: issues connects and waits for an answer
module channel_model
  import tape_connect_pkg::*;
#(
  parameter int TMO = 60
) (
  input wire logic ref_clk,
  input wire logic reply,
  input wire logic reject,
  output tape_connect_pkg::connect_bus_t lines
);
  timeunit 1ns;
  timeprecision 1ps;

  // Lines idle low until the first connect
  initial begin
    lines = '0;
  end

  // One connect: raise, wait for reply, reject or timeout, then withdraw
  task automatic connect(input logic [`CODE_W-1:0] code, input logic bad_par,
                         output logic [1:0] ans);
    int n;
    @(negedge ref_clk);
    lines.code = code;
    lines.parity = ~(^code) ^ bad_par;
    lines.strobe = 1'b1;
    ans = 2'b00;
    n = 0;
    while (ans == 2'b00 && n < TMO) begin
      @(negedge ref_clk);
      ans = {reject, reply};
      n++;
    end
    // Released code and parity show the inverse of the last value
    lines = {1'b0, ~lines.parity, ~lines.code};
    n = 0;
    while ((reply | reject) !== 1'b0 && n < 10) begin
      @(negedge ref_clk);
      n++;
    end
    // Let the timing chain settle back to idle
    repeat (4) @(negedge ref_clk);
  endtask
endmodule

// ---- test/tape_unit_connect_sequencer_bench.sv ----
`include "tape_connect_map.svh"

`define CHK(nm, exp, got) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
      fail_count++; \
      $display("wrong value %s expected %h seen %h", nm, exp, got); \
    end \
  end

// ==========================================================
// Self-checking bench for the connect sequencer
module tape_unit_connect_sequencer_bench
  import tape_connect_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [2:0] EQ = 3'h5;
  logic ref_clk = 1'b0;
  logic rst_n, master_clear, op_act, clr_fn, rel_fn, en;
  logic [2:0] eq_sw;
  unit_addr_t ua;
  unit_status_t ts;
  connect_bus_t lines;
  logic reply, reject, conn, cip, perr, red, white, ops;
  logic [7:0] sel;
  logic [10:0] stat;
  logic [1:0] ans;
  int fail_count = 0;
  int n_checks = 0;

  // Clock at 125 MHz
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  channel_model #(.TMO(60)) i_chan (.ref_clk(ref_clk), .reply(reply), .reject(reject),
    .lines(lines));

  tape_unit_connect_sequencer i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(en),
    .master_clear(master_clear), .connect_lines(lines), .equipment_number_switch(eq_sw),
    .operation_active_term(op_act), .clear_function(clr_fn), .release_function(rel_fn),
    .unit_address_lines(ua), .transport_status(ts), .reply(reply), .reject(reject),
    .controller_connected_flag(conn), .connect_in_progress_flag(cip),
    .transmission_parity_error_flag(perr), .red_lamp_driver(red),
    .white_lamp_driver(white), .unit_select(sel), .operations_enable(ops),
    .status_lines(stat));

  // Verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Connect with varied middle bits, compare answer and selection
  task automatic conn_chk(input logic [2:0] eq, input logic [2:0] u, input logic bad,
                          input logic [1:0] exp_ans, input logic [7:0] exp_sel);
    i_chan.connect({eq, 6'(u * 7), u}, bad, ans);
    `CHK("answer", exp_ans, ans)
    `CHK("unit select", exp_sel, sel)
    `CHK("answer withdrawn", 2'b00, {reject, reply})
    `CHK("in progress", 1'b0, cip)
  endtask

  // Hang guard
  initial begin
    repeat (100000) @(posedge ref_clk);
    fail_count++;
    close_out();
  end

  // Main sequence; transport t reports unit 7-t
  initial begin
    {rst_n, master_clear, op_act, clr_fn, rel_fn} = 5'h00;
    en = 1'b1;
    eq_sw = EQ;
    for (int t = 0; t < 8; t++) begin
      ua[t] = 8'h01 << (7 - t);
      ts[t] = 11'(t * 165 + 3);
    end
    repeat (20) @(negedge ref_clk);
    rst_n = 1'b1;
    `CHK("connected after reset", 1'b0, conn)
    for (int u = 0; u < 8; u++) begin
      conn_chk(EQ, 3'(u), 1'b0, 2'b01, 8'h80 >> u);
      `CHK("connected lamp enable", 3'b111, {conn, white, ops})
      `CHK("status", ts[7-u], stat)
    end
    // Selector turned on the connected transport
    ua[0] = 8'h00;
    repeat (4) @(negedge ref_clk);
    `CHK("select after zero address", 8'h00, sel)
    conn_chk(EQ, 3'h7, 1'b0, 2'b10, 8'h00);
    ua[0] = 8'h80;
    // Clear then release function drop the selection
    for (int f = 0; f < 2; f++) begin
      conn_chk(EQ, 3'h2, 1'b0, 2'b01, 8'h20);
      {rel_fn, clr_fn} = 2'(f + 1);
      @(negedge ref_clk);
      {rel_fn, clr_fn} = 2'b00;
      @(negedge ref_clk);
      `CHK("select after function", 8'h00, sel)
    end
    // Operation in progress refuses the connect
    conn_chk(EQ, 3'h1, 1'b0, 2'b01, 8'h40);
    op_act = 1'b1;
    conn_chk(EQ, 3'h4, 1'b0, 2'b10, 8'h40);
    `CHK("connected while busy", 1'b1, conn)
    op_act = 1'b0;
    // Parity fault stays silent and lights the red lamp
    conn_chk(EQ, 3'h4, 1'b1, 2'b00, 8'h00);
    `CHK("parity flag lamp conn", 3'b110, {perr, red, conn})
    conn_chk(EQ, 3'h4, 1'b0, 2'b01, 8'h08);
    `CHK("parity flag cleared", 1'b0, perr)
    // Connect for another controller drops this one
    conn_chk(EQ ^ 3'h3, 3'h4, 1'b0, 2'b00, 8'h00);
    `CHK("connected after foreign", 1'b0, conn)
    // Master clear removes connection and status
    conn_chk(EQ, 3'h6, 1'b0, 2'b01, 8'h02);
    master_clear = 1'b1;
    @(negedge ref_clk);
    master_clear = 1'b0;
    repeat (4) @(negedge ref_clk);
    `CHK("after master clear", 20'h00000, {conn, sel, stat})
    // Low clock enable freezes the selection against a clear function
    conn_chk(EQ, 3'h3, 1'b0, 2'b01, 8'h10);
    en = 1'b0;
    clr_fn = 1'b1;
    repeat (3) @(negedge ref_clk);
    `CHK("select while frozen", 8'h10, sel)
    {en, clr_fn} = 2'b10;
    repeat (2) @(negedge ref_clk);
    `CHK("select after thaw", 8'h10, sel)
    // Reset in mid-run drops the connection, then a connect works again
    rst_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    `CHK("after mid-run reset", 9'h000, {conn, sel})
    conn_chk(EQ, 3'h0, 1'b0, 2'b01, 8'h80);
    close_out();
  end
endmodule
